/* File: core/ext_bus_port.sv */
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ext_bus_port
  import ext_bus_pkg::*;
#(
  parameter int unsigned WF_DEPTH = 4,
  parameter int unsigned RF_DEPTH = 8,
  parameter int unsigned NCH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // processor window
  input wire logic cpu_sel,
  input wire logic cpu_write,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  // external bus
  output logic ext_clk,
  output logic [1:0] ext_mode,
  output logic ext_req,
  output logic ext_we,
  output logic [31:0] ext_addr,
  output logic [31:0] ext_wdata,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  // dma and interrupt
  output logic dma_rd_req,
  output logic irq
);

  localparam int unsigned WPW = $clog2(WF_DEPTH);
  localparam int unsigned RPW = $clog2(RF_DEPTH);
  localparam int unsigned CHW = (NCH > 1) ? $clog2(NCH) : 1;

  // refused at elaboration, not at run time
  if (WF_DEPTH < 2 || (WF_DEPTH & (WF_DEPTH - 1)) != 0 || WF_DEPTH > 8) begin : g_bad_wf
    $error("WF_DEPTH must be a power of two from 2 to 8");
  end
  if (RF_DEPTH < 2 || (RF_DEPTH & (RF_DEPTH - 1)) != 0 || RF_DEPTH > 8) begin : g_bad_rf
    $error("RF_DEPTH must be a power of two from 2 to 8");
  end
  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("NCH must be 1 to 4");
  end

  function automatic logic [31:0] ram_base(input logic [1:0] code);
    return (code == 2'h1) ? RAM_BASE_6 : (code == 2'h2) ? RAM_BASE_8 : 32'h0000_0000;
  endfunction : ram_base

  function automatic logic [31:0] per_base(input logic [1:0] code);
    return (code == 2'h1) ? PER_BASE_A : (code == 2'h2) ? PER_BASE_C : 32'h0000_0000;
  endfunction : per_base

  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base, input logic [1:0] sz);
    logic [31:0] lim;
    lim = (sz == 2'h0) ? SIZE_256B : (sz == 2'h1) ? SIZE_64KB : (sz == 2'h2) ? SIZE_16MB : SIZE_512MB;
    return (base != 32'h0000_0000) && ((a - base) < lim);
  endfunction : win_hit

  function automatic logic [31:0] item_mask(input logic [1:0] sz, input logic [31:0] d);
    return (sz == ITEM_8) ? {24'h00_0000, d[7:0]} : (sz == ITEM_16) ? {16'h0000, d[15:0]} : d;
  endfunction : item_mask

  function automatic logic [31:0] item_bytes(input logic [1:0] sz);
    return (sz == ITEM_8) ? 32'h0000_0001 : (sz == ITEM_16) ? 32'h0000_0002 : 32'h0000_0004;
  endfunction : item_bytes

  // control registers
  logic [1:0] mode_q;
  logic [15:0] div_q;
  addr_map_t map_q;
  fifo_lvl_t lvl_q;
  logic [2:0] int_en_q;
  logic [1:0] err_q;
  logic [1:0] ch_size_q [NCH];
  logic [31:0] ch_addr_q [NCH];
  logic [31:0] ch_left_q [NCH];

  // fifos
  wr_entry_t wf_mem [WF_DEPTH];
  logic [WPW-1:0] wf_rd_q, wf_wr_q;
  logic [WPW:0] wf_cnt_q;
  logic [31:0] rf_mem [RF_DEPTH];
  logic [RPW-1:0] rf_rd_q, rf_wr_q;
  logic [RPW:0] rf_cnt_q;

  // external engine and flops behind outputs
  ext_state_t st_q;
  owner_t own_q;
  logic [CHW-1:0] own_ch_q;
  logic [15:0] div_cnt_q;
  logic ext_clk_q, ext_req_q, ext_we_q;
  logic [31:0] ext_addr_q, ext_wdata_q;
  logic [2:0] ack_s;
  logic [31:0] rdat_s0, rdat_s1, rdat_s2;
  logic pready_q, pslverr_q, cpu_ready_q, cpu_rd_pend_q, irq_q, dma_q;
  logic [31:0] prdata_q, cpu_rdata_q, cpu_off_q;

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign cpu_ready = cpu_ready_q;
  assign cpu_rdata = cpu_rdata_q;
  assign ext_clk = ext_clk_q;
  assign ext_mode = mode_q;
  assign ext_req = ext_req_q;
  assign ext_we = ext_we_q;
  assign ext_addr = ext_addr_q;
  assign ext_wdata = ext_wdata_q;
  assign dma_rd_req = dma_q;
  assign irq = irq_q;

  // window decode
  logic ram_hit, per_hit, cpu_hit, cpu_take;
  logic [31:0] cpu_off;
  assign ram_hit = win_hit(cpu_addr, ram_base(map_q.ram_base), map_q.ram_size);
  assign per_hit = win_hit(cpu_addr, per_base(map_q.per_base), map_q.per_size);
  assign cpu_hit = ram_hit || per_hit;
  assign cpu_off = ram_hit ? cpu_addr - ram_base(map_q.ram_base) : cpu_addr - per_base(map_q.per_base);
  assign cpu_take = cpu_sel && !cpu_ready_q && !cpu_rd_pend_q;

  logic wf_full, wf_push, wf_pop, rf_push, rf_pop, ack_hi, ack_lo, tick, ext_done;
  logic seq_go, start_wr, start_cpu, start_seq, wr_stall, rd_stall;
  logic [CHW-1:0] seq_ch;
  assign wf_full = (wf_cnt_q == (WPW + 1)'(WF_DEPTH));
  assign wr_stall = cpu_take && cpu_hit && cpu_write && wf_full;
  assign wf_push = cpu_take && cpu_hit && cpu_write && !wf_full;
  // ack counts once second and third stages agree
  assign ack_hi = ack_s[1] && ack_s[2];
  assign ack_lo = !ack_s[1] && !ack_s[2];
  // transactions launch on external clock rise
  assign tick = (div_cnt_q == div_q) && !ext_clk_q;
  assign ext_done = (st_q == EXT_REQ) && ack_hi;
  assign wf_pop = ext_done && own_q == OWN_WR;
  assign rf_push = ext_done && own_q == OWN_SEQ;

  // lowest busy channel wins while read fifo has room
  always_comb begin
    seq_go = 1'b0;
    seq_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ch_left_q[i] != 32'h0000_0000) begin
        seq_go = 1'b1;
        seq_ch = CHW'(i);
      end
    end
    if (rf_cnt_q >= (RPW + 1)'(RF_DEPTH))
      seq_go = 1'b0;
  end

  // buffered writes drain first so a blocking read sees them
  assign start_wr = (st_q == EXT_IDLE) && tick && wf_cnt_q != '0;
  assign start_cpu = (st_q == EXT_IDLE) && tick && wf_cnt_q == '0 && cpu_rd_pend_q;
  assign start_seq = (st_q == EXT_IDLE) && tick && wf_cnt_q == '0 && !cpu_rd_pend_q && seq_go;

  // apb decode
  logic apb_acc, apb_wr, ch_hit, rd_ok;
  logic [11:0] ch_off, ch_fld;
  logic [CHW-1:0] ch_idx;
  logic [31:0] rd_val;
  logic [2:0] int_raw;
  assign apb_acc = psel && penable && !pready_q;
  assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign ch_off = paddr - OFF_CH_BASE;
  assign ch_fld = ch_off % CH_STRIDE;
  assign ch_hit = paddr >= OFF_CH_BASE && (ch_off / CH_STRIDE) < 12'(NCH) && ch_fld <= CH_COUNT;
  assign ch_idx = CHW'(ch_off / CH_STRIDE);
  // data read waits for an item
  assign rd_stall = apb_acc && !pwrite && paddr == OFF_RD_DATA && rf_cnt_q == '0;
  assign rf_pop = psel && penable && pready_q && !pwrite && paddr == OFF_RD_DATA;

  assign int_raw[INT_RD] = rf_cnt_q != '0 && 32'(rf_cnt_q) >= 32'(lvl_q.rd_trig);
  assign int_raw[INT_WR] = 32'(wf_cnt_q) <= 32'(lvl_q.wr_trig);
  assign int_raw[INT_ERR] = |err_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      OFF_MODE: rd_val = 32'(mode_q);
      OFF_DIV: rd_val = 32'(div_q);
      OFF_MAP: rd_val = 32'(map_q);
      OFF_STOP: rd_val = 32'h0000_0000;
      OFF_FIFO_LVL: rd_val = 32'(lvl_q);
      OFF_WR_AVAIL: rd_val = 32'(WF_DEPTH) - 32'(wf_cnt_q);
      OFF_RD_AVAIL: rd_val = 32'(rf_cnt_q);
      OFF_RD_DATA: rd_val = rf_mem[rf_rd_q];
      OFF_INT_EN: rd_val = 32'(int_en_q);
      OFF_INT_RAW: rd_val = 32'(int_raw);
      OFF_INT_MASKED: rd_val = 32'(int_raw & int_en_q);
      OFF_ERR: rd_val = 32'(err_q);
      default: begin
        if (!ch_hit)
          rd_ok = 1'b0;
        else if (ch_fld == CH_CFG)
          rd_val = 32'(ch_size_q[ch_idx]);
        else if (ch_fld == CH_ADDR)
          rd_val = ch_addr_q[ch_idx];
        else if (ch_fld == CH_COUNT)
          rd_val = ch_left_q[ch_idx];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  // apb handshake: one wait state, longer on an empty fifo read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      if (apb_acc && !rd_stall) begin
        pready_q <= 1'b1;
        pslverr_q <= !rd_ok;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
      div_q <= DIV_RESET;
      map_q <= '0;
      lvl_q <= '0;
      int_en_q <= '0;
    end else if (apb_wr) begin
      if (paddr == OFF_MODE)
        mode_q <= pwdata[1:0];
      if (paddr == OFF_DIV)
        div_q <= pwdata[15:0];
      if (paddr == OFF_MAP)
        map_q <= addr_map_t'(pwdata[$bits(addr_map_t)-1:0]);
      if (paddr == OFF_FIFO_LVL)
        lvl_q <= fifo_lvl_t'(pwdata[$bits(fifo_lvl_t)-1:0]);
      if (paddr == OFF_INT_EN)
        int_en_q <= pwdata[2:0];
    end
  end

  // sequential read channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ch_size_q[i] <= ITEM_32;
        ch_addr_q[i] <= 32'h0000_0000;
        ch_left_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (start_seq) begin
        ch_addr_q[seq_ch] <= ch_addr_q[seq_ch] + item_bytes(ch_size_q[seq_ch]);
        ch_left_q[seq_ch] <= ch_left_q[seq_ch] - 32'h0000_0001;
      end
      if (apb_wr && ch_hit && ch_fld == CH_CFG)
        ch_size_q[ch_idx] <= pwdata[1:0];
      if (apb_wr && ch_hit && ch_fld == CH_ADDR)
        ch_addr_q[ch_idx] <= pwdata;
      // start with a count, stop halts further reads
      if (apb_wr && ch_hit && ch_fld == CH_COUNT)
        ch_left_q[ch_idx] <= pwdata;
      for (int i = 0; i < NCH; i++) begin
        if (apb_wr && paddr == OFF_STOP && pwdata[i])
          ch_left_q[i] <= 32'h0000_0000;
      end
    end
  end

  // write fifo count up on buffer, down on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wf_rd_q <= '0;
      wf_wr_q <= '0;
      wf_cnt_q <= '0;
    end else begin
      if (wf_push) begin
        wf_mem[wf_wr_q] <= '{addr: cpu_off, data: cpu_wdata};
        wf_wr_q <= wf_wr_q + 1'b1;
      end
      if (wf_pop)
        wf_rd_q <= wf_rd_q + 1'b1;
      wf_cnt_q <= wf_cnt_q + (WPW + 1)'(wf_push) - (WPW + 1)'(wf_pop);
    end
  end

  // read fifo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_rd_q <= '0;
      rf_wr_q <= '0;
      rf_cnt_q <= '0;
    end else begin
      // stored at the channel's item width
      if (rf_push) begin
        rf_mem[rf_wr_q] <= item_mask(ch_size_q[own_ch_q], rdat_s2);
        rf_wr_q <= rf_wr_q + 1'b1;
      end
      if (rf_pop)
        rf_rd_q <= rf_rd_q + 1'b1;
      rf_cnt_q <= rf_cnt_q + (RPW + 1)'(rf_push) - (RPW + 1)'(rf_pop);
    end
  end

  // processor window answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ready_q <= 1'b0;
      cpu_rd_pend_q <= 1'b0;
      cpu_rdata_q <= 32'h0000_0000;
      cpu_off_q <= 32'h0000_0000;
    end else begin
      cpu_ready_q <= 1'b0;
      if (cpu_take && !cpu_hit) begin
        cpu_ready_q <= 1'b1;
        cpu_rdata_q <= 32'h0000_0000;
      end
      if (wf_push)
        cpu_ready_q <= 1'b1;
      // window read becomes a blocking external read
      if (cpu_take && cpu_hit && !cpu_write) begin
        cpu_rd_pend_q <= 1'b1;
        cpu_off_q <= cpu_off;
      end
      if (ext_done && own_q == OWN_CPU) begin
        cpu_ready_q <= 1'b1;
        cpu_rd_pend_q <= 1'b0;
        cpu_rdata_q <= rdat_s2;
      end
    end
  end

  // bus clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 16'h0000;
      ext_clk_q <= 1'b0;
    end else if (div_cnt_q >= div_q) begin
      div_cnt_q <= 16'h0000;
      ext_clk_q <= !ext_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // pin inputs; first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s <= 3'h0;
      rdat_s0 <= 32'h0000_0000;
      rdat_s1 <= 32'h0000_0000;
      rdat_s2 <= 32'h0000_0000;
    end else begin
      ack_s <= {ack_s[1:0], ext_ack};
      rdat_s0 <= ext_rdata;
      rdat_s1 <= rdat_s0;
      rdat_s2 <= rdat_s1;
    end
  end

  // four-phase request/acknowledge on the external side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= EXT_IDLE;
      own_q <= OWN_WR;
      own_ch_q <= '0;
      ext_req_q <= 1'b0;
      ext_we_q <= 1'b0;
      ext_addr_q <= 32'h0000_0000;
      ext_wdata_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        EXT_IDLE: begin
          if (start_wr || start_cpu || start_seq) begin
            st_q <= EXT_REQ;
            ext_req_q <= 1'b1;
            ext_we_q <= start_wr;
          end
          if (start_wr) begin
            own_q <= OWN_WR;
            ext_addr_q <= wf_mem[wf_rd_q].addr;
            ext_wdata_q <= wf_mem[wf_rd_q].data;
          end else if (start_cpu) begin
            own_q <= OWN_CPU;
            ext_addr_q <= cpu_off_q;
          end else if (start_seq) begin
            own_q <= OWN_SEQ;
            own_ch_q <= seq_ch;
            ext_addr_q <= ch_addr_q[seq_ch];
          end
        end
        EXT_REQ: begin
          if (ack_hi) begin
            ext_req_q <= 1'b0;
            st_q <= EXT_RELEASE;
          end
        end
        EXT_RELEASE: begin
          // waiting for ack low keeps a slow peer from being double counted
          if (ack_lo)
            st_q <= EXT_IDLE;
        end
      endcase
    end
  end

  // error flags, interrupt and dma request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 2'h0;
      irq_q <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      // write one to clear; a new stall in the same cycle wins
      err_q[ERR_RD] <= (err_q[ERR_RD] && !(apb_wr && paddr == OFF_ERR && pwdata[ERR_RD]))
                       || (rd_stall && lvl_q.rd_err_en);
      err_q[ERR_WR] <= (err_q[ERR_WR] && !(apb_wr && paddr == OFF_ERR && pwdata[ERR_WR]))
                       || (wr_stall && lvl_q.wr_err_en);
      irq_q <= |(int_raw & int_en_q);
      // dma drain request at read trigger
      dma_q <= int_raw[INT_RD];
    end
  end

endmodule : ext_bus_port

`default_nettype wire

/* File: core/ext_bus_pkg.sv */
`default_nettype none
package ext_bus_pkg;

  // apb register byte offsets
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_DIV = 12'h004;
  localparam logic [11:0] OFF_MAP = 12'h008;
  localparam logic [11:0] OFF_STOP = 12'h00c;
  localparam logic [11:0] OFF_FIFO_LVL = 12'h010;
  localparam logic [11:0] OFF_WR_AVAIL = 12'h014;
  localparam logic [11:0] OFF_RD_AVAIL = 12'h018;
  localparam logic [11:0] OFF_RD_DATA = 12'h01c;
  localparam logic [11:0] OFF_INT_EN = 12'h020;
  localparam logic [11:0] OFF_INT_RAW = 12'h024;
  localparam logic [11:0] OFF_INT_MASKED = 12'h028;
  localparam logic [11:0] OFF_ERR = 12'h02c;
  localparam logic [11:0] OFF_CH_BASE = 12'h040;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [11:0] CH_CFG = 12'h000;
  localparam logic [11:0] CH_ADDR = 12'h004;
  localparam logic [11:0] CH_COUNT = 12'h008;

  // external interface modes
  localparam logic [1:0] MODE_SDRAM = 2'h0;
  localparam logic [1:0] MODE_HOST = 2'h1;
  localparam logic [1:0] MODE_GP = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_SDRAM;
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // window bases and sizes
  localparam logic [31:0] RAM_BASE_6 = 32'h6000_0000;
  localparam logic [31:0] RAM_BASE_8 = 32'h8000_0000;
  localparam logic [31:0] PER_BASE_A = 32'ha000_0000;
  localparam logic [31:0] PER_BASE_C = 32'hc000_0000;
  localparam logic [31:0] SIZE_256B = 32'h0000_0100;
  localparam logic [31:0] SIZE_64KB = 32'h0001_0000;
  localparam logic [31:0] SIZE_16MB = 32'h0100_0000;
  localparam logic [31:0] SIZE_512MB = 32'h2000_0000;

  // read item sizes
  localparam logic [1:0] ITEM_8 = 2'h0;
  localparam logic [1:0] ITEM_16 = 2'h1;
  localparam logic [1:0] ITEM_32 = 2'h2;

  // interrupt and error bit positions
  localparam int unsigned INT_RD = 0;
  localparam int unsigned INT_WR = 1;
  localparam int unsigned INT_ERR = 2;
  localparam int unsigned ERR_RD = 0;
  localparam int unsigned ERR_WR = 1;

  typedef struct packed {
    logic [1:0] per_size;
    logic [1:0] per_base;
    logic [1:0] ram_size;
    logic [1:0] ram_base;
  } addr_map_t;

  typedef struct packed {
    logic wr_err_en;
    logic rd_err_en;
    logic [2:0] wr_trig;
    logic [3:0] rd_trig;
  } fifo_lvl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } wr_entry_t;

  typedef enum {EXT_IDLE, EXT_REQ, EXT_RELEASE} ext_state_t;
  typedef enum {OWN_WR, OWN_CPU, OWN_SEQ} owner_t;

endpackage : ext_bus_pkg
`default_nettype wire

/* File: verif/ext_bus_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_port_checker
  import ext_bus_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // window, external bus, interrupt
  input wire logic cpu_ready,
  input wire logic ext_clk,
  input wire logic [1:0] ext_mode,
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  input wire logic ext_ack,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_done;
  logic clk_d_q;
  logic [1:0] mode_q;
  logic [2:0] en_q;
  logic [1:0] en_zero_q;
  logic [15:0] div_q;
  logic [16:0] still_q;
  assign wr_done = psel && penable && pwrite && pready;
  // limit only grows, so a shorter divisor never trips a half period still running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
      div_q <= DIV_RESET;
      en_q <= 3'h0;
      en_zero_q <= 2'h0;
    end else begin
      if (wr_done && paddr == OFF_MODE) mode_q <= pwdata[1:0];
      if (wr_done && paddr == OFF_DIV && pwdata[15:0] > div_q) div_q <= pwdata[15:0];
      if (wr_done && paddr == OFF_INT_EN) begin
        en_q <= pwdata[2:0];
        en_zero_q <= 2'h0;
      end else if (en_q == 3'h0 && en_zero_q != 2'h3) begin
        en_zero_q <= en_zero_q + 2'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d_q <= 1'b0;
      still_q <= 17'h0;
    end else begin
      clk_d_q <= ext_clk;
      still_q <= (ext_clk != clk_d_q) ? 17'h0 : still_q + 17'h1;
    end
  end
  AST_MODE_PINS: assert property (wr_done && paddr == OFF_MODE |-> ##2 ext_mode == mode_q)
    else $error("mode pins do not follow the mode register");
  AST_CLK_HALF: assert property (still_q <= {1'b0, div_q} + 17'h2)
    else $error("external clock half period too long");
  AST_REQ_HOLD: assert property (ext_req && !ext_ack |=>
    ext_req && $stable(ext_addr) && $stable(ext_we) && $stable(ext_wdata))
    else $error("request changed before acknowledge");
  AST_REQ_DROP: assert property ($rose(ext_ack) && ext_req |-> ##[1:6] !ext_req)
    else $error("request not released after acknowledge");
  AST_REQ_IDLE: assert property ($rose(ext_req) |-> !ext_ack)
    else $error("request raised while acknowledge still high");
  AST_CPU_PULSE: assert property (cpu_ready |=> !cpu_ready)
    else $error("processor ready longer than one cycle");
  AST_APB_WAIT: assert property (psel && penable && !pready && paddr != OFF_RD_DATA |=> pready)
    else $error("register access exceeded one wait state");
  AST_IRQ_OFF: assert property (en_zero_q == 2'h3 |-> !irq)
    else $error("interrupt raised with all enables off");
  cover property (wr_done && paddr == OFF_STOP);
  cover property ($rose(ext_ack) && ext_req && ext_we);
  cover property (psel && penable && !pready ##3 !pready);
endmodule : ext_bus_port_checker
`default_nettype wire

/* File: verif/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // clock and pacing
  input wire logic pclk,
  input wire logic [3:0] wait_cyc,
  // external bus
  input wire logic ext_req,
  input wire logic [31:0] ext_addr,
  output logic ext_ack,
  output logic [31:0] ext_rdata
);
  logic [3:0] wait_q = 4'h0;
  initial ext_ack = 1'b0;
  initial ext_rdata = 32'h0;
  // idle data keeps flipping so a capture outside the acknowledge shows up
  always @(posedge pclk) begin
    if (ext_req && !ext_ack) begin
      if (wait_q >= wait_cyc) begin
        ext_ack <= 1'b1;
        ext_rdata <= {~ext_addr[15:0], ext_addr[15:0]};
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
        ext_rdata <= ~ext_rdata;
      end
    end else if (!ext_req) begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule : ext_mem_model
`default_nettype wire

/* File: verif/external_bus_transaction_buffering_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_transaction_buffering_tb
  import ext_bus_pkg::*;
;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic err;
  } note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_sel, cpu_write, cpu_ready;
  logic ext_clk, ext_req, ext_we, ext_ack, dma_rd_req, irq;
  logic ack_d = 1'b0;
  logic [1:0] ext_mode;
  logic [3:0] wait_cyc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpu_addr, cpu_wdata, cpu_rdata, ext_addr, ext_wdata, ext_rdata, r, d;
  note_t apb_q[$];
  logic [31:0] cpu_q[$];
  logic [63:0] wr_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat;
  integer seed = 32'h095de5d2;
  time t0;

  ext_bus_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .cpu_sel, .cpu_write, .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_rdata, .ext_clk,
    .ext_mode, .ext_req, .ext_we, .ext_addr, .ext_wdata, .ext_ack, .ext_rdata, .dma_rd_req, .irq);
  ext_mem_model far_end (.pclk, .wait_cyc, .ext_req, .ext_addr, .ext_ack, .ext_rdata);

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction : pat

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task report_and_stop;
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dv, ev, mv, input logic ee);
    apb_q.push_back({ev, mv, ee});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] dv);
    apb(1'b1, a, dv, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ev, mv);
    apb(1'b0, a, 32'h0, ev, mv, 1'b0);
  endtask : rd

  task automatic poll(input logic [11:0] a, input logic [31:0] v);
    do rd(a, 32'h0, 32'h0); while (r !== v);
  endtask : poll

  task automatic cpu(input logic w, input logic [31:0] a, dv, ev);
    cpu_q.push_back(ev);
    @(posedge pclk);
    cpu_sel <= 1'b1;
    cpu_write <= w;
    cpu_addr <= a;
    cpu_wdata <= dv;
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
    end while (cpu_ready !== 1'b1);
    cpu_sel <= 1'b0;
  endtask : cpu

  always @(posedge pclk) begin
    note_t n;
    if (psel && penable && pready === 1'b1) begin
      n = apb_q.pop_front();
      chk("apb", {n.e, n.err}, {prdata & n.m, pslverr});
    end
    if (cpu_ready === 1'b1) chk("cpu_rdata", cpu_q.pop_front(), cpu_rdata);
    if (ext_req && ext_we && ext_ack && !ack_d) chk("ext_write", wr_q.pop_front(), {ext_addr, ext_wdata});
    ack_d <= ext_ack;
  end

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, cpu_sel, cpu_write} = 6'h0;
    {paddr, pwdata, cpu_addr, cpu_wdata, wait_cyc} = 112'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_MODE, 32'h0, '1);
    rd(OFF_DIV, {16'h0, DIV_RESET}, '1);
    rd(OFF_WR_AVAIL, 32'h4, '1);
    rd(OFF_RD_AVAIL, 32'h0, '1);
    rd(OFF_CH_BASE + CH_CFG, {30'h0, ITEM_32}, '1);
    apb(1'b0, 12'h3fc, 32'h0, 32'h0, '1, 1'b1);
    for (int m = 0; m < 3; m++) begin
      wr(OFF_MODE, m);
      rd(OFF_MODE, m, '1);
    end
    wr(OFF_DIV, 32'h3);
    repeat (3) @(posedge ext_clk);
    t0 = $time;
    @(posedge ext_clk);
    chk("ext_clk_period", 64'd320, $time - t0);
    for (int b = 1; b < 3; b++) begin
      wr(OFF_MAP, (b << 4) | (b << 2) | b);
      cpu(1'b0, (b == 1 ? RAM_BASE_6 : RAM_BASE_8) + 32'h10, 32'h0, pat(32'h10));
      cpu(1'b0, (b == 1 ? PER_BASE_A : PER_BASE_C) + 32'h20, 32'h0, pat(32'h20));
      cpu(1'b0, (b == 1 ? RAM_BASE_8 : RAM_BASE_6) + 32'h10, 32'h0, 32'h0);
      chk("miss_latency", 2, lat);
      cpu(1'b0, (b == 1 ? PER_BASE_A : PER_BASE_C) + SIZE_256B, 32'h0, 32'h0);
    end
    wr(OFF_MAP, 32'hd);
    wr(OFF_FIFO_LVL, 32'h182);
    wr(OFF_INT_EN, 32'h4);
    wait_cyc <= 4'hf;
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      wr_q.push_back({32'(i * 4), d});
      cpu(1'b1, RAM_BASE_6 + 32'(i * 4), d, 32'h0);
      if (i < 4) chk("buffered_write_latency", 2, lat);
      else chk("full_write_stalls", 1, lat > 2);
      if (i == 3) rd(OFF_WR_AVAIL, 32'h0, '1);
    end
    rd(OFF_ERR, 32'h2, 32'h3);
    chk("irq", 1, irq);
    rd(OFF_INT_MASKED, 32'h4, '1);
    rd(OFF_INT_RAW, 32'h4, 32'h4);
    wr(OFF_ERR, 32'h3);
    rd(OFF_ERR, 32'h0, 32'h3);
    wr(OFF_INT_EN, 32'h0);
    poll(OFF_WR_AVAIL, 32'h4);
    rd(OFF_WR_AVAIL, 32'h4, '1);
    for (int s = 0; s < 3; s++) begin
      wait_cyc <= 4'($random(seed)) & 4'h7;
      wr(OFF_CH_BASE + CH_CFG, s);
      wr(OFF_CH_BASE + CH_ADDR, 32'h100);
      wr(OFF_CH_BASE + CH_COUNT, 32'h2);
      poll(OFF_RD_AVAIL, 32'h2);
      rd(OFF_CH_BASE + CH_COUNT, 32'h0, '1);
      chk("dma_rd_req", 1, dma_rd_req);
      for (int k = 0; k < 2; k++) rd(OFF_RD_DATA, pat(32'h100 + (k << s)) & ((32'h1 << (8 << s)) - 32'h1), '1);
      rd(OFF_RD_AVAIL, 32'h0, '1);
    end
    wait_cyc <= 4'h8;
    wr(OFF_CH_BASE + CH_STRIDE + CH_ADDR, 32'h200);
    wr(OFF_CH_BASE + CH_STRIDE + CH_COUNT, 32'h6);
    wr(OFF_STOP, 32'h2);
    rd(OFF_CH_BASE + CH_STRIDE + CH_COUNT, 32'h0, '1);
    repeat (60) @(posedge pclk);
    chk("ext_req_after_stop", 0, ext_req);
    rd(OFF_RD_AVAIL, 32'h0, 32'h0);
    chk("items_after_stop", 1, r <= 2);
    d = r;
    repeat (d) rd(OFF_RD_DATA, 32'h0, 32'h0);
    wr(OFF_CH_BASE + CH_STRIDE + CH_ADDR, 32'h300);
    wr(OFF_CH_BASE + CH_STRIDE + CH_COUNT, 32'h1);
    rd(OFF_RD_DATA, pat(32'h300), '1);
    rd(OFF_ERR, 32'h1, 32'h3);
    report_and_stop;
  end
endmodule : external_bus_transaction_buffering_tb

bind ext_bus_port ext_bus_port_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .cpu_ready, .ext_clk, .ext_mode, .ext_req, .ext_we, .ext_addr, .ext_wdata,
  .ext_ack, .irq);
`default_nettype wire
